//--- shared/rac_pkg.sv
// Purpose: constants for the regeneration avoidance control block
// Assumes: bus voltage in volts, frequencies in 0.01 Hz units, gains in percent
// Notes: one control tick per sample strobe
// Overview of operation
// - raise frequency when bus voltage reaches level
// - mode 0 off, 1 always, 2 constant speed
// - voltage level accepted from 300 to 800 V
// - sensitivity 1..5, higher detects smaller rises
// - sensitivity zero disables change-ratio detection
// - steep rise during deceleration halts deceleration; no halt on a tick that also reaches level
// - accel/constant: output below held plus limit
// - decel overshoot holds limit until half limit
// - raised frequency clamped to maximum frequency
// - limit 9999 bounds compensation by maximum frequency instead
// - voltage gain 0..200 percent, speeds response
// - frequency gain 0..200 percent scales correction
// - correction slope follows regeneration severity
// - avoidance raises frequency, not merely holds
// - stall flag asserted while avoidance acts
// - stall prevention active while avoidance acts
package rac_pkg;
	localparam int VOLT_W = 10;
	localparam int FREQ_W = 16;
	localparam int GAIN_W = 8;
	localparam logic [VOLT_W-1:0] LEVEL_MIN = 10'h12C;
	localparam logic [VOLT_W-1:0] LEVEL_MAX = 10'h320;
	localparam logic [2:0] SENS_MAX = 3'h5;
	localparam logic [FREQ_W-1:0] LIMIT_MAX = 16'h0BB8;
	localparam logic [FREQ_W-1:0] LIMIT_OFF = 16'h270F;
	localparam logic [FREQ_W-1:0] LIMIT_DEFAULT = 16'h0258;
	localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hC8;
	localparam logic [GAIN_W-1:0] GAIN_DEFAULT = 8'h64;
	localparam logic [VOLT_W-1:0] RATIO_BASE = 10'h018;
	localparam logic [VOLT_W-1:0] RATIO_STEP = 10'h004;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ALWAYS = 2'h1;
	localparam logic [1:0] MODE_CONST = 2'h2;
	typedef enum logic [1:0] {
		RAC_IDLE = 2'b00,
		RAC_ACTIVE = 2'b01,
		RAC_HOLD = 2'b11
	} rac_state_type;
endpackage

//--- rtl/rac_regen_avoid.sv
// Purpose: regeneration avoidance frequency compensation
// Assumes: settings stable between ticks; inputs synchronous to core_clk
// Notes: accel_state 0 constant, 1 accelerating, 2 decelerating
`timescale 1ns/1ps
module rac_regen_avoid #(
	parameter int VOLT_W = rac_pkg::VOLT_W,
	parameter int FREQ_W = rac_pkg::FREQ_W
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic sample_tick,
	input wire logic [VOLT_W-1:0] bus_voltage,
	input wire logic [FREQ_W-1:0] output_frequency,
	input wire logic [1:0] accel_state,
	input wire logic [1:0] avoidance_mode_select,
	input wire logic [VOLT_W-1:0] avoidance_voltage_level,
	input wire logic [2:0] change_ratio_sensitivity,
	input wire logic [FREQ_W-1:0] compensation_frequency_limit,
	input wire logic [7:0] avoidance_voltage_gain,
	input wire logic [7:0] avoidance_frequency_gain,
	input wire logic [FREQ_W-1:0] maximum_output_frequency,
	output logic [FREQ_W-1:0] compensated_frequency,
	output logic stall_active_flag,
	output logic stall_prevention_active,
	output logic decel_halt,
	output logic setting_error
);
	logic [VOLT_W-1:0] prev_voltage, next_prev_voltage;
	logic [FREQ_W-1:0] base_freq, next_base_freq;
	logic [FREQ_W-1:0] comp, next_comp;
	logic [FREQ_W-1:0] next_out;
	logic next_flag, next_halt, next_err;
	rac_pkg::rac_state_type state, next_state;
	logic [FREQ_W-1:0] lim;
	logic [FREQ_W-1:0] eff_lim;
	logic [VOLT_W-1:0] lvl;
	logic [7:0] vg, fg;
	logic enabled, level_hit, ratio_hit;
	logic [VOLT_W:0] rise;
	logic [VOLT_W-1:0] ratio_thr;
	logic [FREQ_W+16:0] step;
	logic [FREQ_W+1:0] sum;

	// saturating clamp of a wide value to a bound
	function automatic logic [FREQ_W-1:0] clamp(input logic [FREQ_W+1:0] v, input logic [FREQ_W-1:0] b);
		clamp = (v > {2'b00, b}) ? b : v[FREQ_W-1:0];
	endfunction

	// gains above the range saturate rather than wrap
	function automatic logic [7:0] clip_gain(input logic [7:0] g);
		clip_gain = (g > rac_pkg::GAIN_MAX) ? rac_pkg::GAIN_MAX : g;
	endfunction

	always_comb begin
		// out-of-range level, gain and limit settings fall back to the nearest legal value
		lvl = avoidance_voltage_level;
		if (lvl < rac_pkg::LEVEL_MIN) begin
			lvl = rac_pkg::LEVEL_MIN;
		end else if (lvl > rac_pkg::LEVEL_MAX) begin
			lvl = rac_pkg::LEVEL_MAX;
		end
		vg = clip_gain(avoidance_voltage_gain);
		fg = clip_gain(avoidance_frequency_gain);
		lim = compensation_frequency_limit;
		if (lim != rac_pkg::LIMIT_OFF && lim > rac_pkg::LIMIT_MAX) begin
			lim = rac_pkg::LIMIT_MAX;
		end
		next_err = (avoidance_voltage_level < rac_pkg::LEVEL_MIN) || (avoidance_voltage_level > rac_pkg::LEVEL_MAX)
			|| (change_ratio_sensitivity > rac_pkg::SENS_MAX) || (avoidance_mode_select == 2'h3);
		eff_lim = (lim == rac_pkg::LIMIT_OFF) ? maximum_output_frequency : lim;
		case (avoidance_mode_select)
			rac_pkg::MODE_ALWAYS: enabled = 1'b1;
			rac_pkg::MODE_CONST: enabled = (accel_state == 2'h0);
			default: enabled = 1'b0;
		endcase
		level_hit = enabled && (bus_voltage >= lvl);
		rise = {1'b0, bus_voltage} - {1'b0, prev_voltage};
		// higher sensitivity means a smaller threshold per tick
		ratio_thr = rac_pkg::RATIO_BASE - VOLT_W'(change_ratio_sensitivity) * rac_pkg::RATIO_STEP;
		ratio_hit = enabled && (accel_state == 2'h2) && (change_ratio_sensitivity != 3'h0)
			&& (change_ratio_sensitivity <= rac_pkg::SENS_MAX) && !rise[VOLT_W]
			&& (rise[VOLT_W-1:0] > ratio_thr) && !level_hit;
		next_prev_voltage = prev_voltage;
		next_base_freq = base_freq;
		next_comp = comp;
		next_state = state;
		next_halt = 1'b0;
		step = '0;
		sum = '0;
		if (sample_tick) begin
			next_prev_voltage = bus_voltage;
			// a ratio hit halts deceleration from any state, the first detection included
			next_halt = ratio_hit;
			// step grows with overshoot times both gains
			if (level_hit) begin
				step = (FREQ_W+17)'(bus_voltage - lvl + 10'h001) * vg * fg;
			end
			case (state)
				rac_pkg::RAC_IDLE: begin
					next_base_freq = output_frequency;
					next_comp = '0;
					if (level_hit || ratio_hit) begin
						next_state = rac_pkg::RAC_ACTIVE;
					end
				end
				rac_pkg::RAC_ACTIVE: begin
					// product bits above this slice stay zero for every legal setting
					sum = {2'b00, comp} + clamp(step[FREQ_W+13:12], eff_lim);
					if (!level_hit && !ratio_hit) begin
						// decay halves the correction each tick
						sum = (comp > 16'h0001) ? {3'b000, comp[FREQ_W-1:1]} : '0;
					end
					next_comp = clamp(sum, eff_lim);
					if (accel_state == 2'h2 && sum > {2'b00, eff_lim} && lim != rac_pkg::LIMIT_OFF) begin
						next_state = rac_pkg::RAC_HOLD;
					end else if (next_comp == '0 && !level_hit && !ratio_hit) begin
						next_state = rac_pkg::RAC_IDLE;
					end
				end
				rac_pkg::RAC_HOLD: begin
					next_comp = eff_lim;
					if (output_frequency <= {1'b0, lim[FREQ_W-1:1]}) begin
						next_state = rac_pkg::RAC_IDLE;
						next_comp = '0;
					end
				end
				default: next_state = rac_pkg::RAC_IDLE;
			endcase
		end else begin
			next_halt = decel_halt;
		end
		// limit referenced to frequency held before avoidance; clamp to max
		sum = {2'b00, ((state == rac_pkg::RAC_IDLE) ? output_frequency : base_freq)} + {2'b00, next_comp};
		next_out = clamp(sum, maximum_output_frequency);
		if (next_state == rac_pkg::RAC_IDLE) begin
			next_out = output_frequency;
		end
		next_flag = (next_state != rac_pkg::RAC_IDLE);
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state <= rac_pkg::RAC_IDLE;
			prev_voltage <= '0;
			base_freq <= '0;
			comp <= '0;
			compensated_frequency <= '0;
			stall_active_flag <= 1'b0;
			stall_prevention_active <= 1'b0;
			decel_halt <= 1'b0;
			setting_error <= 1'b0;
		end else begin
			state <= next_state;
			prev_voltage <= next_prev_voltage;
			base_freq <= next_base_freq;
			comp <= next_comp;
			compensated_frequency <= next_out;
			stall_active_flag <= next_flag;
			stall_prevention_active <= next_flag;
			decel_halt <= next_halt;
			setting_error <= next_err;
		end
	end

	a_flag_tracks_state: assert property (@(posedge core_clk) disable iff (!nrst)
		stall_active_flag == (state != rac_pkg::RAC_IDLE)) else $error("stall flag mismatch");
	a_prevent_with_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		stall_prevention_active == stall_active_flag) else $error("stall prevention mismatch");
	// the clamp used the maximum as it stood one edge earlier
	a_max_clamp: assert property (@(posedge core_clk) disable iff (!nrst)
		state != rac_pkg::RAC_IDLE |-> compensated_frequency <= $past(maximum_output_frequency))
		else $error("above maximum frequency");
	a_mode_off_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		avoidance_mode_select == rac_pkg::MODE_OFF && state == rac_pkg::RAC_IDLE && sample_tick
		|=> state == rac_pkg::RAC_IDLE) else $error("avoidance started while off");
	a_level_starts: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_tick && state == rac_pkg::RAC_IDLE && level_hit |=> stall_active_flag)
		else $error("level hit did not start avoidance");
	a_sens_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		change_ratio_sensitivity == 3'h0 |-> !ratio_hit) else $error("ratio detect with zero sensitivity");
	a_comp_bound: assert property (@(posedge core_clk) disable iff (!nrst)
		comp <= rac_pkg::LIMIT_MAX || lim == rac_pkg::LIMIT_OFF) else $error("compensation above limit");
	a_halt_on_ratio: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_tick && ratio_hit |=> decel_halt) else $error("decel not halted");
	c_level_entry: cover property (@(posedge core_clk) disable iff (!nrst) state == rac_pkg::RAC_ACTIVE);
	c_hold_entry: cover property (@(posedge core_clk) disable iff (!nrst) state == rac_pkg::RAC_HOLD);
	c_ratio_halt: cover property (@(posedge core_clk) disable iff (!nrst) decel_halt);
	c_hold_exit: cover property (@(posedge core_clk) disable iff (!nrst)
		state == rac_pkg::RAC_HOLD ##1 state == rac_pkg::RAC_IDLE);
	c_no_limit: cover property (@(posedge core_clk) disable iff (!nrst)
		state == rac_pkg::RAC_ACTIVE && lim == rac_pkg::LIMIT_OFF);
	// tick checks look one edge later, against the settings that made the update
	a_hold_keeps: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_tick && state == rac_pkg::RAC_HOLD && output_frequency > {1'b0, lim[FREQ_W-1:1]}
		|=> state == rac_pkg::RAC_HOLD) else $error("hold released early");
	a_hold_release: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_tick && state == rac_pkg::RAC_HOLD && output_frequency <= {1'b0, lim[FREQ_W-1:1]}
		|=> !stall_active_flag && compensated_frequency == $past(output_frequency))
		else $error("hold not released");
	a_comp_limit: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_tick && state == rac_pkg::RAC_ACTIVE && lim != rac_pkg::LIMIT_OFF |=> comp <= $past(lim))
		else $error("compensation above limit setting");
	a_no_limit: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_tick && state == rac_pkg::RAC_ACTIVE && lim == rac_pkg::LIMIT_OFF
		|=> comp <= $past(maximum_output_frequency)) else $error("unlimited compensation above maximum");
	a_zero_gain: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_tick && state == rac_pkg::RAC_ACTIVE && level_hit && (vg == 8'h00 || fg == 8'h00)
		&& comp <= eff_lim |=> comp == $past(comp)) else $error("zero gain still moved frequency");
	a_decay_halves: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_tick && state == rac_pkg::RAC_ACTIVE && !level_hit && !ratio_hit && comp <= eff_lim
		|=> comp == ($past(comp) >> 1)) else $error("decay not halving");
	a_still_between: assert property (@(posedge core_clk) disable iff (!nrst)
		!sample_tick |=> state == $past(state) && comp == $past(comp)) else $error("update between ticks");
	a_sens_error: assert property (@(posedge core_clk) disable iff (!nrst)
		change_ratio_sensitivity > rac_pkg::SENS_MAX |=> setting_error) else $error("bad sensitivity not flagged");
	a_mode_error: assert property (@(posedge core_clk) disable iff (!nrst)
		avoidance_mode_select == 2'h3 |=> setting_error) else $error("bad mode not flagged");
endmodule // rac_regen_avoid

//--- testbench/rac_drive_model.sv
// Purpose: drive side model, bus voltage sensing and output stage
// Assumes: one control tick every 4 core_clk cycles
// Notes: levels follow the bench directly; only the tick is generated here
`timescale 1ns/1ps
module rac_drive_model (
	input wire logic core_clk,
	input wire logic [9:0] set_volt,
	input wire logic [15:0] set_freq,
	input wire logic [1:0] set_accel,
	output logic sample_tick,
	output logic [9:0] bus_voltage,
	output logic [15:0] output_frequency,
	output logic [1:0] accel_state
);
	logic [1:0] cnt = 2'h0;
	logic tick_q = 1'h0;
	// tick moves on the falling edge so the design's rising edge sees it settled
	always @(negedge core_clk) begin
		cnt <= cnt + 2'h1;
		tick_q <= (cnt == 2'h3);
	end
	assign sample_tick = tick_q;
	// pass-through: copying on the bench's own falling edge would race its blocking writes
	assign bus_voltage = set_volt;
	assign output_frequency = set_freq;
	assign accel_state = set_accel;
endmodule // rac_drive_model

//--- testbench/rac_regen_avoid_tb.sv
// Purpose: self-checking bench for the regeneration avoidance block
// Assumes: expectations follow the hand-over step and hold behaviour
// Notes: checks land on the falling edge after each tick
`timescale 1ns/1ps
module rac_regen_avoid_tb;
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic [1:0] mode = 2'h1;
	logic [9:0] lvl = 10'h17C;
	logic [2:0] sens = 3'h0;
	logic [15:0] lim = 16'h0258;
	logic [7:0] vg = 8'h64;
	logic [7:0] fg = 8'h64;
	logic [15:0] maxf = 16'h1770;
	logic [9:0] volt = 10'h12C;
	logic [15:0] freq = 16'h03E8;
	logic [1:0] acc = 2'h0;
	logic tick, flag, prev, halt, serr, seen;
	logic [9:0] bv;
	logic [15:0] of, cf;
	logic [1:0] ast;
	logic [1:0] mt [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
	logic [1:0] at [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
	logic [2:0] st [3] = '{3'h5, 3'h1, 3'h0};
	int n_mismatch = 0;
	int total_checks = 0;
	always #4 core_clk = ~core_clk;
	rac_drive_model i_rac_drive_model (.core_clk(core_clk), .set_volt(volt), .set_freq(freq), .set_accel(acc),
		.sample_tick(tick), .bus_voltage(bv), .output_frequency(of), .accel_state(ast));
	rac_regen_avoid i_rac_regen_avoid (.core_clk(core_clk), .nrst(nrst), .sample_tick(tick), .bus_voltage(bv),
		.output_frequency(of), .accel_state(ast), .avoidance_mode_select(mode), .avoidance_voltage_level(lvl),
		.change_ratio_sensitivity(sens), .compensation_frequency_limit(lim), .avoidance_voltage_gain(vg),
		.avoidance_frequency_gain(fg), .maximum_output_frequency(maxf), .compensated_frequency(cf),
		.stall_active_flag(flag), .stall_prevention_active(prev), .decel_halt(halt), .setting_error(serr));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chb(input logic g, input logic e);
		chk({15'h0000, g}, {15'h0000, e});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// bounded wait for n ticks; records any halt seen after each of them
	task automatic ticks(input int n);
		int w;
		seen = 1'h0;
		repeat (n) begin
			w = 0;
			@(posedge core_clk);
			while (tick !== 1'h1 && w < 20) begin
				@(posedge core_clk);
				w++;
			end
			if (w == 20) begin
				n_mismatch++;
				close_out();
			end
			@(negedge core_clk);
			seen = seen | halt;
		end
	endtask
	// below level the correction decays; 17 ticks empties any 16-bit value
	task automatic idle();
		volt = 10'h12C;
		ticks(17);
	endtask
	initial begin
		repeat (4) @(negedge core_clk);
		chk(cf, 16'h0000);
		chb(flag, 1'h0);
		nrst = 1'h1;
		volt = 10'h17C;
		ticks(1);
		chb(flag, 1'h1);
		chb(prev, 1'h1);
		chk(cf, 16'h03E8);
		idle();
		chb(flag, 1'h0);
		$display("level test done");
		for (int i = 0; i < 4; i++) begin
			mode = mt[i];
			acc = at[i];
			volt = 10'h190;
			ticks(1);
			chb(flag, (i == 1 || i == 2));
			idle();
		end
		$display("mode test done");
		mode = 2'h3;
		@(negedge core_clk);
		chb(serr, 1'h1);
		mode = 2'h1;
		sens = 3'h6;
		@(negedge core_clk);
		chb(serr, 1'h1);
		sens = 3'h0;
		@(negedge core_clk);
		chb(serr, 1'h0);
		acc = 2'h2;
		for (int i = 0; i < 3; i++) begin
			sens = st[i];
			ticks(2);
			volt = 10'h136;
			ticks(2);
			chb(seen, (i == 0));
			idle();
		end
		$display("ratio test done");
		sens = 3'h0;
		lim = 16'h0064;
		volt = 10'h190;
		ticks(3);
		chk(cf, 16'h044C);
		volt = 10'h12C;
		ticks(3);
		chk(cf, 16'h044C);
		freq = 16'h0032;
		ticks(17);
		chk(cf, 16'h0032);
		freq = 16'h03E8;
		acc = 2'h0;
		vg = 8'h00;
		volt = 10'h1DF;
		ticks(3);
		chk(cf, 16'h03E8);
		idle();
		vg = 8'hC8;
		fg = 8'hC8;
		volt = 10'h1DF;
		ticks(4);
		chk(cf, 16'h044C);
		maxf = 16'h041A;
		ticks(1);
		chk(cf, 16'h041A);
		lim = 16'h270F;
		maxf = 16'h05DC;
		ticks(4);
		chk(cf, 16'h05DC);
		$display("limit test done");
		close_out();
	end
endmodule // rac_regen_avoid_tb
